/* File: src/starter_supervision.sv */
`timescale 1ns/10ps
module starter_supervision #(
  parameter int TICK_CYCLES = starter_pkg::TICK_CYC,
  parameter int AOUT_CYCLES = starter_pkg::AOUT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Field pins
  input wire logic line_sensed_in,
  input wire logic run_contactor_feedback_in,
  input wire logic start_in,
  input wire logic keypad_stop_in,
  input wire logic stop_in,
  // Same-clock inputs
  input wire logic up_to_speed_relay_in,
  input wire logic modbus_valid_in,
  input wire logic [6:0] aout_level_in,
  // Starter control and status
  output logic run_out,
  output logic ready_out,
  output logic no_line_alarm_out,
  output logic missing_line_fault_out,
  output logic fault_out,
  output logic [7:0] fault_code_out,
  output logic controlled_stop_out,
  output logic reprogram_indication_out,
  output logic remote_display_en_out,
  // Commands, serial setup, analog output
  output starter_pkg::cmd_pulse_t cmd_out,
  output starter_pkg::serial_cfg_t serial_out,
  output logic [13:0] aout_value_out
);
  localparam int P_LINE = 0;
  localparam int P_FB = 1;
  localparam int P_START = 2;
  localparam int P_KSTOP = 3;
  localparam int P_STOP = 4;

  typedef struct packed {
    starter_pkg::cfg_t cfg;
    starter_pkg::cfg_t bak;
    logic [15:0] rdata;
    logic [4:0] sy0;
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [4:0] flt;
    logic start_prev;
    logic [21:0] tick_cnt;
    logic tick;
    logic [19:0] aout_cnt;
    logic aout_en;
    logic [15:0] baud_cnt;
    logic baud_en;
    logic [7:0] noline_cnt;
    logic [5:0] byp_cnt;
    logic [10:0] comto_cnt;
    logic [1:0] pwr_wait;
    logic pwr_done;
    logic run;
    logic [2:0] fault;
    logic [7:0] fault_code;
    logic ctl_stop;
    logic reflash;
    starter_pkg::cmd_pulse_t cmd;
  } sup_st_t;

  sup_st_t s_r, s_nxt;
  logic inline_on;
  logic kp_stop_eff;
  logic start_edge;
  logic fault_clr;
  logic auto_pwr;
  logic auto_flt;
  logic start_req;
  logic noline_set;
  logic byp_set;
  logic comto_set;
  logic [2:0] fault_set;
  logic stop_any;
  logic [10:0] comto_lim;
  logic wr_ok;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.aout_en = 1'b0;
    s_nxt.baud_en = 1'b0;
    s_nxt.ctl_stop = 1'b0;
    s_nxt.cmd = '0;
    // Three-stage pin capture; a change counts when stages two and three agree
    s_nxt.sy0 = {stop_in, keypad_stop_in, start_in, run_contactor_feedback_in,
      line_sensed_in};
    s_nxt.sy1 = s_r.sy0;
    s_nxt.sy2 = s_r.sy1;
    s_nxt.flt = ((s_r.sy1 ~^ s_r.sy2) & s_r.sy2) | ((s_r.sy1 ^ s_r.sy2) & s_r.flt);
    s_nxt.start_prev = s_r.flt[P_START];

    if (s_r.tick_cnt == 22'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 22'h000001;
    end
    if (s_r.aout_cnt == 20'(AOUT_CYCLES - 1)) begin
      s_nxt.aout_cnt = '0;
      s_nxt.aout_en = 1'b1;
    end else begin
      s_nxt.aout_cnt = s_r.aout_cnt + 20'h00001;
    end
    // bit-rate enable for the serial link
    if (s_r.baud_cnt >= starter_pkg::baud_div(s_r.cfg.baud) - 16'h0001) begin
      s_nxt.baud_cnt = '0;
      s_nxt.baud_en = 1'b1;
    end else begin
      s_nxt.baud_cnt = s_r.baud_cnt + 16'h0001;
    end

    // Power-up auto start is checked once, a cycle before the start filter follows the pin
    if (s_r.pwr_wait != 2'b11) begin
      s_nxt.pwr_wait = s_r.pwr_wait + 2'b01;
    end else begin
      s_nxt.pwr_done = 1'b1;
    end

    if (s_r.run && inline_on && !s_r.flt[P_LINE]) begin
      if (s_r.tick) begin
        s_nxt.noline_cnt = s_r.noline_cnt + 8'h01;
      end
    end else begin
      s_nxt.noline_cnt = '0;
    end
    // mismatch timer, restarts when states agree
    if (s_r.cfg.bypass_dly != 6'h00 && (s_r.flt[P_FB] != up_to_speed_relay_in)) begin
      if (s_r.tick && !byp_set) begin
        s_nxt.byp_cnt = s_r.byp_cnt + 6'h01;
      end
    end else begin
      s_nxt.byp_cnt = '0;
    end
    if (s_r.cfg.comto == 7'h00 || !s_r.run || modbus_valid_in) begin
      s_nxt.comto_cnt = '0;
    end else if (s_r.tick && !comto_set) begin
      s_nxt.comto_cnt = s_r.comto_cnt + 11'h001;
    end
    s_nxt.ctl_stop = comto_set;

    // Sticky faults: a new fault beats a reset in the same cycle
    s_nxt.fault = (s_r.fault & {3{~fault_clr}}) | fault_set;
    if (fault_set[0]) begin
      s_nxt.fault_code = starter_pkg::FLT_NOLINE;
    end else if (fault_set[1]) begin
      s_nxt.fault_code = starter_pkg::FLT_BYPASS;
    end else if (fault_set[2]) begin
      s_nxt.fault_code = starter_pkg::FLT_COMTO;
    end else if (fault_clr) begin
      s_nxt.fault_code = 8'h00;
    end

    // stops and faults beat any start
    if (stop_any) begin
      s_nxt.run = 1'b0;
    end else if (start_req) begin
      s_nxt.run = 1'b1;
    end

    // Register reads, answered in the following cycle
    s_nxt.rdata = '0;
    if (rd_in) begin
      if (addr_in == starter_pkg::REG_SPAN) begin
        s_nxt.rdata = {9'h000, s_r.cfg.span};
      end else if (addr_in == starter_pkg::REG_OFFSET) begin
        s_nxt.rdata = {9'h000, s_r.cfg.offset};
      end else if (addr_in == starter_pkg::REG_INLINE) begin
        s_nxt.rdata = {8'h00, s_r.cfg.inline_dly};
      end else if (addr_in == starter_pkg::REG_BYPASS) begin
        s_nxt.rdata = {10'h000, s_r.cfg.bypass_dly};
      end else if (addr_in == starter_pkg::REG_CTRL) begin
        s_nxt.rdata = {11'h000, s_r.cfg.source, s_r.cfg.auto_mode, s_r.cfg.kp_stop_en};
      end else if (addr_in == starter_pkg::REG_COMTO) begin
        s_nxt.rdata = {9'h000, s_r.cfg.comto};
      end else if (addr_in == starter_pkg::REG_BAUD) begin
        s_nxt.rdata = {13'h0000, s_r.cfg.baud};
      end else if (addr_in == starter_pkg::REG_ADDR) begin
        s_nxt.rdata = {8'h00, s_r.cfg.addr};
      end else if (addr_in == starter_pkg::REG_FRAME) begin
        s_nxt.rdata = {14'h0000, s_r.cfg.frame};
      end else if (addr_in == starter_pkg::REG_STATUS) begin
        s_nxt.rdata = {s_r.fault_code, s_r.reflash, s_r.fault, ready_out,
          no_line_alarm_out, s_r.flt[P_LINE], s_r.run};
      end
    end

    // Register writes; out-of-range values leave the setting unchanged
    if (wr_ok) begin
      if (addr_in == starter_pkg::REG_SPAN) begin
        if (wdata_in[15:7] == 9'h000 && wdata_in[6:0] != 7'h00
            && wdata_in[6:0] <= starter_pkg::SPAN_MAX) begin
          s_nxt.cfg.span = wdata_in[6:0];
        end
      end else if (addr_in == starter_pkg::REG_OFFSET) begin
        if (wdata_in[15:7] == 9'h000 && wdata_in[6:0] <= starter_pkg::OFFSET_MAX) begin
          s_nxt.cfg.offset = wdata_in[6:0];
        end
      end else if (addr_in == starter_pkg::REG_INLINE) begin
        if (wdata_in[15:8] == 8'h00 && (wdata_in[7:0] <= starter_pkg::INLINE_MAX
            || wdata_in[7:0] == starter_pkg::INLINE_OFF)) begin
          s_nxt.cfg.inline_dly = wdata_in[7:0];
        end
      end else if (addr_in == starter_pkg::REG_BYPASS) begin
        if (wdata_in[15:6] == 10'h000 && wdata_in[5:0] <= starter_pkg::BYPASS_MAX) begin
          s_nxt.cfg.bypass_dly = wdata_in[5:0];
        end
      end else if (addr_in == starter_pkg::REG_CTRL) begin
        if (wdata_in[4:3] != 2'b11) begin
          s_nxt.cfg.kp_stop_en = wdata_in[0];
          s_nxt.cfg.auto_mode = starter_pkg::auto_t'(wdata_in[2:1]);
          s_nxt.cfg.source = starter_pkg::src_t'(wdata_in[4:3]);
        end
      end else if (addr_in == starter_pkg::REG_CMD) begin
        case (wdata_in[3:0])
          starter_pkg::CMD_TEST: s_nxt.cmd.self_test = 1'b1;
          starter_pkg::CMD_PTEST: s_nxt.cmd.powered_test = 1'b1;
          starter_pkg::CMD_CLR_RT: s_nxt.cmd.clr_runtime = 1'b1;
          starter_pkg::CMD_CLR_KWH: s_nxt.cmd.clr_energy = 1'b1;
          starter_pkg::CMD_REFLASH: s_nxt.reflash = !s_r.run && !start_req;
          starter_pkg::CMD_STORE: begin
            s_nxt.bak = s_r.cfg;
            s_nxt.cmd.store = 1'b1;
          end
          starter_pkg::CMD_LOAD: begin
            s_nxt.cfg = s_r.bak;
            s_nxt.cmd.load = 1'b1;
          end
          starter_pkg::CMD_FACTORY: begin
            s_nxt.cfg = starter_pkg::CFG_DEFAULT;
            s_nxt.cmd.factory = 1'b1;
          end
          default: s_nxt.cmd = '0;
        endcase
      end else if (addr_in == starter_pkg::REG_COMTO) begin
        // timeout off or 1 to 120 s
        if (wdata_in[15:7] == 9'h000 && wdata_in[6:0] <= starter_pkg::COMTO_MAX) begin
          s_nxt.cfg.comto = wdata_in[6:0];
        end
      end else if (addr_in == starter_pkg::REG_BAUD) begin
        if (wdata_in[15:3] == 13'h0000 && wdata_in[2:0] <= 3'b100) begin
          s_nxt.cfg.baud = starter_pkg::baud_t'(wdata_in[2:0]);
        end
      end else if (addr_in == starter_pkg::REG_ADDR) begin
        if (wdata_in[15:8] == 8'h00 && wdata_in[7:0] != 8'h00
            && wdata_in[7:0] <= starter_pkg::ADDR_MAX) begin
          s_nxt.cfg.addr = wdata_in[7:0];
        end
      end else if (addr_in == starter_pkg::REG_FRAME) begin
        if (wdata_in[15:2] == 14'h0000) begin
          s_nxt.cfg.frame = starter_pkg::frame_t'(wdata_in[1:0]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reflash freezes configuration; only a power cycle leaves it
  assign wr_ok = wr_in && !s_r.reflash;
  assign inline_on = s_r.cfg.inline_dly != starter_pkg::INLINE_OFF;
  assign fault_clr = wr_ok && addr_in == starter_pkg::REG_STATUS && wdata_in[0];
  // disabled key still works from keypad source
  // enabled key works from every source
  assign kp_stop_eff = s_r.flt[P_KSTOP]
    && (s_r.cfg.kp_stop_en || s_r.cfg.source == starter_pkg::SRC_KEYPAD);
  // outside the fault-reset auto start, only a fresh rising edge starts
  assign start_edge = s_r.flt[P_START] && !s_r.start_prev;
  // level start on fault reset; the power-up term sees the start filter still low
  assign auto_pwr = s_r.pwr_wait == 2'b11 && !s_r.pwr_done && s_r.flt[P_START]
    && s_r.cfg.auto_mode[0];
  assign auto_flt = fault_clr && s_r.fault != 3'b000 && s_r.flt[P_START]
    && s_r.cfg.auto_mode[1];
  assign start_req = (start_edge || auto_pwr || auto_flt) && !s_r.run && !s_r.reflash;
  // start with no line and no inline contactor
  assign noline_set = (start_req && !inline_on && !s_r.flt[P_LINE])
    || (inline_on && s_r.run && !s_r.flt[P_LINE]
        && s_r.noline_cnt >= s_r.cfg.inline_dly);
  // mismatch goes straight to the fault, no alarm
  assign byp_set = s_r.cfg.bypass_dly != 6'h00 && s_r.byp_cnt >= s_r.cfg.bypass_dly;
  assign comto_lim = 11'(s_r.cfg.comto) * 11'(starter_pkg::TICKS_PER_SEC);
  assign comto_set = s_r.cfg.comto != 7'h00 && s_r.run && !modbus_valid_in
    && s_r.comto_cnt >= comto_lim;
  assign fault_set = {comto_set, byp_set, noline_set};
  // A fault being reset no longer blocks the auto start it enables
  assign stop_any = kp_stop_eff || s_r.flt[P_STOP] || (s_r.fault != 3'b000 && !fault_clr)
    || fault_set != 3'b000 || s_r.reflash;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.cfg <= starter_pkg::CFG_DEFAULT;
      s_r.bak <= starter_pkg::CFG_DEFAULT;
    end else begin
      s_r <= s_nxt;
    end
  end

  aout_scale u_aout (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .refresh_in(s_r.aout_en),
    .level_in(aout_level_in),
    .span_in(s_r.cfg.span),
    .offset_in(s_r.cfg.offset),
    .value_out(aout_value_out)
  );

  ////////////////////////////////////////////////////////////////////////
  assign rdata_out = s_r.rdata;
  assign run_out = s_r.run;
  // alarm and not ready while stopped
  assign no_line_alarm_out = !inline_on && !s_r.run && !s_r.flt[P_LINE];
  assign ready_out = s_r.fault == 3'b000 && !s_r.reflash
    && (inline_on || s_r.flt[P_LINE]);
  assign missing_line_fault_out = s_r.fault[0];
  assign fault_out = s_r.fault != 3'b000;
  assign fault_code_out = s_r.fault_code;
  assign controlled_stop_out = s_r.ctl_stop;
  assign reprogram_indication_out = s_r.reflash;
  assign remote_display_en_out = !s_r.reflash;
  assign cmd_out = s_r.cmd;
  assign serial_out = '{baud: s_r.cfg.baud, frame: s_r.cfg.frame,
    addr: s_r.cfg.addr, bit_en: s_r.baud_en};

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence mismatch_expired;
    s_r.cfg.bypass_dly != 6'h00 && s_r.byp_cnt >= s_r.cfg.bypass_dly;
  endsequence
  sequence bypass_tripped;
    s_r.fault[1] && s_r.fault_code == 8'h30 && !s_r.run;
  endsequence

  noline_alarm_a: assert property (!inline_on && !s_r.flt[P_LINE] && !s_r.run
    |-> no_line_alarm_out && !ready_out) else $error("no-line alarm missing");
  inline_ready_a: assert property (inline_on && s_r.fault == 3'b000
    && !s_r.reflash |-> !no_line_alarm_out && ready_out) else $error("inline ready wrong");
  bypass_trip_a: assert property (mismatch_expired |=> bypass_tripped)
    else $error("bypass fault not declared");
  keypad_stop_a: assert property (kp_stop_eff |=> !run_out)
    else $error("keypad stop ignored");
  edge_start_a: assert property ($rose(run_out) && s_r.cfg.auto_mode == 2'b00
    |-> $past(s_r.flt[P_START]) && !$past(s_r.start_prev)) else $error("start without edge");
  reflash_hold_a: assert property (reprogram_indication_out
    |-> !run_out && !remote_display_en_out) else $error("reflash not halting");
  comto_stop_a: assert property ($rose(s_r.fault[2]) |-> controlled_stop_out
    && fault_code_out == 8'h52 && !run_out) else $error("timeout stop missing");
  tick_gap_a: assert property (s_r.tick |=> !s_r.tick[*2])
    else $error("tick too frequent");
  fault_override_a: assert property (fault_out |-> !run_out)
    else $error("running with fault");
  clear_meter_a: assert property (wr_ok && addr_in == 4'h5 && wdata_in[3:0] == 4'h3
    |=> cmd_out.clr_runtime ##1 !cmd_out.clr_runtime) else $error("run-time clear missing");
endmodule // starter_supervision

/* File: src/starter_pkg.sv */
// Functional notes
// - Analog output scaled by span 1-125%
// - Analog output clamped at full scale
// - Offset 0-99% added to spanned value
// - Inline off, no line: alarm while stopped, not ready
// - Inline delay: no alarm, delayed no-line fault
// - Feedback differs from relay: fault 48
// - No alarm for feedback mismatch
// - Disabled keypad stop works only from keypad
// - Enabled keypad stop works from any source
// - Auto-start off: start on rising edge
// - Auto-start on fault reset; power-up auto-start never fires
// - Decode command codes 0 to 8
// - Reflash only idle; halts until power cycle
// - Clear run-time or energy meters
// - Store, load, factory-default parameter sets
// - Serial request timeout: fault 82, controlled stop
// - Bit rate 1200 to 19200, default 19200
// - Station address 1-247, default 1
// - Analog output refreshed every 25 ms
// - Framing even, odd, none, none two-stop
package starter_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int AOUT_MS = 25;
  localparam int AOUT_CYC = CLK_HZ / 1000 * AOUT_MS;
  localparam logic [13:0] AOUT_FULL = 14'h2710;
  localparam logic [3:0] TICKS_PER_SEC = 4'hA;
  // Register offsets
  localparam logic [3:0] REG_SPAN = 4'h0;
  localparam logic [3:0] REG_OFFSET = 4'h1;
  localparam logic [3:0] REG_INLINE = 4'h2;
  localparam logic [3:0] REG_BYPASS = 4'h3;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h5;
  localparam logic [3:0] REG_COMTO = 4'h6;
  localparam logic [3:0] REG_BAUD = 4'h7;
  localparam logic [3:0] REG_ADDR = 4'h8;
  localparam logic [3:0] REG_FRAME = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'hA;
  // Limits and special codes
  localparam logic [6:0] SPAN_MAX = 7'h7D;
  localparam logic [6:0] OFFSET_MAX = 7'h63;
  localparam logic [7:0] INLINE_MAX = 8'h64;
  localparam logic [7:0] INLINE_OFF = 8'hFF;
  localparam logic [5:0] BYPASS_MAX = 6'h32;
  localparam logic [6:0] COMTO_MAX = 7'h78;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [7:0] FLT_NOLINE = 8'h01;
  localparam logic [7:0] FLT_BYPASS = 8'h30;
  localparam logic [7:0] FLT_COMTO = 8'h52;
  // Bit-rate divisors at 25 MHz
  localparam logic [15:0] DIV_1200 = 16'h5161;
  localparam logic [15:0] DIV_2400 = 16'h28B1;
  localparam logic [15:0] DIV_4800 = 16'h1458;
  localparam logic [15:0] DIV_9600 = 16'h0A2C;
  localparam logic [15:0] DIV_19200 = 16'h0516;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_TEST = 4'h1, CMD_PTEST = 4'h2,
    CMD_CLR_RT = 4'h3, CMD_CLR_KWH = 4'h4, CMD_REFLASH = 4'h5,
    CMD_STORE = 4'h6, CMD_LOAD = 4'h7, CMD_FACTORY = 4'h8
  } cmd_t;
  typedef enum logic [1:0] {
    AUTO_OFF = 2'b00, AUTO_POWER = 2'b01, AUTO_FAULT = 2'b10, AUTO_BOTH = 2'b11
  } auto_t;
  typedef enum logic [1:0] {
    SRC_KEYPAD = 2'b00, SRC_TERMINAL = 2'b01, SRC_SERIAL = 2'b10
  } src_t;
  typedef enum logic [2:0] {
    BAUD_1200 = 3'b000, BAUD_2400 = 3'b001, BAUD_4800 = 3'b010,
    BAUD_9600 = 3'b011, BAUD_19200 = 3'b100
  } baud_t;
  typedef enum logic [1:0] {
    FRAME_EVEN1 = 2'b00, FRAME_ODD1 = 2'b01, FRAME_NONE1 = 2'b10, FRAME_NONE2 = 2'b11
  } frame_t;
  typedef struct packed {
    logic [6:0] span;
    logic [6:0] offset;
    logic [7:0] inline_dly;
    logic [5:0] bypass_dly;
    logic kp_stop_en;
    auto_t auto_mode;
    src_t source;
    logic [6:0] comto;
    baud_t baud;
    logic [7:0] addr;
    frame_t frame;
  } cfg_t;
  localparam cfg_t CFG_DEFAULT = '{span: 7'h64, offset: 7'h00,
    inline_dly: 8'h1E, bypass_dly: 6'h14, kp_stop_en: 1'b1,
    auto_mode: AUTO_OFF, source: SRC_TERMINAL, comto: 7'h00,
    baud: BAUD_19200, addr: 8'h01, frame: FRAME_EVEN1};
  typedef struct packed {
    logic self_test;
    logic powered_test;
    logic clr_runtime;
    logic clr_energy;
    logic store;
    logic load;
    logic factory;
  } cmd_pulse_t;
  typedef struct packed {
    baud_t baud;
    frame_t frame;
    logic [7:0] addr;
    logic bit_en;
  } serial_cfg_t;
  function automatic logic [15:0] baud_div(input baud_t b);
    case (b)
      BAUD_1200: baud_div = DIV_1200;
      BAUD_2400: baud_div = DIV_2400;
      BAUD_4800: baud_div = DIV_4800;
      BAUD_9600: baud_div = DIV_9600;
      default: baud_div = DIV_19200;
    endcase
  endfunction
endpackage

/* File: src/aout_scale.sv */
`timescale 1ns/10ps
module aout_scale (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Scaling inputs
  input wire logic refresh_in,
  input wire logic [6:0] level_in,
  input wire logic [6:0] span_in,
  input wire logic [6:0] offset_in,
  // Output in 0.01 percent units
  output logic [13:0] value_out
);
  typedef struct packed {
    logic [13:0] value;
  } aout_st_t;
  aout_st_t s_r, s_nxt;
  logic [14:0] raw;
  assign raw = 15'(level_in) * 15'(span_in) + 15'(offset_in) * 15'(7'h64);
  always_comb begin
    s_nxt = s_r;
    if (refresh_in) begin
      s_nxt.value = (raw > 15'(starter_pkg::AOUT_FULL)) ? starter_pkg::AOUT_FULL : raw[13:0];
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign value_out = s_r.value;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  half_span_a: assert property (refresh_in && level_in == 7'h64 && span_in == 7'h32
    && offset_in == 7'h00 |=> value_out == 14'h1388) else $error("span 50 not half");
  clamp_a: assert property (value_out <= 14'h2710) else $error("output over full");
  offset_half_a: assert property (refresh_in && level_in == 7'h00
    && offset_in == 7'h32 |=> value_out == 14'h1388) else $error("offset 50 not half");
  refresh_only_a: assert property (!$stable(value_out) |-> $past(refresh_in))
    else $error("output moved without refresh");
endmodule // aout_scale

/* File: verif/field_partner.sv */
`timescale 1ns/10ps
module field_partner (
  // Clock
  input wire logic clk_in,
  // Scenario controls
  input wire logic relay_in,
  input wire logic mismatch_in,
  input wire logic poll_en_in,
  // Toward the starter
  output logic feedback_out,
  output logic valid_out
);
  logic [3:0] gap_r = 4'h0;
  assign feedback_out = relay_in ^ mismatch_in;
  always_ff @(posedge clk_in) begin
    gap_r <= gap_r + 4'h1;
    valid_out <= poll_en_in && (gap_r == 4'hF);
  end
endmodule // field_partner

/* File: verif/tb_starter_supervision.sv */
`timescale 1ns/10ps
module tb_starter_supervision;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic line = 1'b1;
  logic start = 1'b0;
  logic kp_stop = 1'b0;
  logic stop = 1'b0;
  logic relay = 1'b0;
  logic bad_fb = 1'b0;
  logic [6:0] level = 7'h00;
  logic fb, valid, run, ready, alarm, nl_flt, fault, cstop, reflash, remote;
  logic [15:0] rdata;
  logic [7:0] code;
  logic [13:0] aout;
  starter_pkg::cmd_pulse_t cmd;
  starter_pkg::serial_cfg_t ser;
  int fail_count = 0;
  int num_checks = 0;
  int cstop_cnt = 0;
  int n = 0;
  logic poll = 1'b1;
  always #20 clk_in = ~clk_in;
  field_partner far (.clk_in(clk_in), .relay_in(relay), .mismatch_in(bad_fb),
    .poll_en_in(poll), .feedback_out(fb), .valid_out(valid));
  starter_supervision #(.TICK_CYCLES(10), .AOUT_CYCLES(8)) dut (.clk_in(clk_in),
    .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .line_sensed_in(line), .run_contactor_feedback_in(fb),
    .start_in(start), .keypad_stop_in(kp_stop), .stop_in(stop),
    .up_to_speed_relay_in(relay), .modbus_valid_in(valid), .aout_level_in(level),
    .run_out(run), .ready_out(ready), .no_line_alarm_out(alarm),
    .missing_line_fault_out(nl_flt), .fault_out(fault), .fault_code_out(code),
    .controlled_stop_out(cstop), .reprogram_indication_out(reflash),
    .remote_display_en_out(remote), .cmd_out(cmd), .serial_out(ser),
    .aout_value_out(aout));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    chk(rdata, exp);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Span, offset, level, expected value
  // last entry is the 80/20 current-loop setting
  logic [6:0] sp [4] = '{7'h32, 7'h7D, 7'h32, 7'h50};
  logic [6:0] of [4] = '{7'h00, 7'h63, 7'h32, 7'h14};
  logic [6:0] lv [4] = '{7'h64, 7'h64, 7'h00, 7'h64};
  logic [13:0] ex [4] = '{14'h1388, 14'h2710, 14'h1388, 14'h2710};
  logic [3:0] cc [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
  // Timeout stop stands one cycle; count every pulse
  always @(negedge clk_in) begin
    if (cstop) begin
      cstop_cnt <= cstop_cnt + 1;
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rd_reg(starter_pkg::REG_SPAN, 16'h0064);
    rd_reg(4'hF, 16'h0000);
    wr_reg(starter_pkg::REG_ADDR, 16'h00F8);
    wr_reg(starter_pkg::REG_ADDR, 16'h00F7);
    @(negedge clk_in);
    chk({8'h00, ser.addr}, 16'h00F7);
    for (int i = 0; i < 7; i++) begin
      wr_reg(starter_pkg::REG_CMD, {12'h000, cc[i]});
      @(negedge clk_in);
      chk({9'h000, cmd}, 16'h0040 >> ((cc[i] < 4'h5) ? cc[i] - 1 : cc[i] - 2));
    end
    chk({8'h00, ser.addr}, 16'h0001);
    wr_reg(starter_pkg::REG_CMD, 16'h0007);
    @(negedge clk_in);
    chk({8'h00, ser.addr}, 16'h00F7);
    for (int i = 0; i < 4; i++) begin
      wr_reg(starter_pkg::REG_SPAN, {9'h000, sp[i]});
      wr_reg(starter_pkg::REG_OFFSET, {9'h000, of[i]});
      level <= lv[i];
      repeat (24) @(negedge clk_in);
      chk({2'h0, aout}, {2'h0, ex[i]});
    end
    wr_reg(starter_pkg::REG_INLINE, 16'h00FF);
    line <= 1'b0;
    repeat (8) @(negedge clk_in);
    chk({14'h0, alarm, ready}, 16'h0002);
    @(posedge clk_in);
    start <= 1'b1;
    repeat (12) @(negedge clk_in);
    chk({7'h0, nl_flt, code}, 16'h0101);
    @(posedge clk_in);
    start <= 1'b0;
    wr_reg(starter_pkg::REG_STATUS, 16'h0001);
    wr_reg(starter_pkg::REG_INLINE, 16'h0005);
    repeat (8) @(negedge clk_in);
    chk({14'h0, alarm, ready}, 16'h0001);
    @(posedge clk_in);
    start <= 1'b1;
    repeat (25) @(negedge clk_in);
    chk({15'h0, fault}, 16'h0000);
    repeat (60) @(negedge clk_in);
    chk({7'h0, nl_flt, code}, 16'h0101);
    @(posedge clk_in);
    start <= 1'b0;
    line <= 1'b1;
    wr_reg(starter_pkg::REG_STATUS, 16'h0001);
    wr_reg(starter_pkg::REG_BYPASS, 16'h0001);
    bad_fb <= 1'b1;
    repeat (40) @(negedge clk_in);
    chk({15'h0, fault}, 16'h0001);
    chk({7'h0, alarm, code}, 16'h0030);
    // Let the feedback filter settle, or the set beats the reset
    @(posedge clk_in);
    bad_fb <= 1'b0;
    repeat (8) @(posedge clk_in);
    start <= 1'b1;
    repeat (8) @(posedge clk_in);
    wr_reg(starter_pkg::REG_STATUS, 16'h0001);
    repeat (12) @(negedge clk_in);
    chk({15'h0, run}, 16'h0000);
    @(posedge clk_in);
    start <= 1'b0;
    repeat (8) @(posedge clk_in);
    start <= 1'b1;
    repeat (12) @(negedge clk_in);
    chk({15'h0, run}, 16'h0001);
    @(posedge clk_in);
    kp_stop <= 1'b1;
    repeat (8) @(negedge clk_in);
    chk({15'h0, run}, 16'h0000);
    @(posedge clk_in);
    kp_stop <= 1'b0;
    start <= 1'b0;
    wr_reg(starter_pkg::REG_CTRL, 16'h0008);
    repeat (8) @(posedge clk_in);
    start <= 1'b1;
    repeat (12) @(posedge clk_in);
    kp_stop <= 1'b1;
    repeat (8) @(negedge clk_in);
    chk({15'h0, run}, 16'h0001);
    wr_reg(starter_pkg::REG_CTRL, 16'h0000);
    repeat (8) @(negedge clk_in);
    chk({15'h0, run}, 16'h0000);
    @(posedge clk_in);
    kp_stop <= 1'b0;
    start <= 1'b0;
    wr_reg(starter_pkg::REG_CTRL, 16'h000D);
    wr_reg(starter_pkg::REG_COMTO, 16'h0001);
    repeat (4) @(posedge clk_in);
    start <= 1'b1;
    repeat (150) @(negedge clk_in);
    chk({15'h0, run}, 16'h0001);
    @(posedge clk_in);
    poll <= 1'b0;
    repeat (140) @(negedge clk_in);
    chk({8'h00, code}, 16'h0052);
    chk(16'(cstop_cnt), 16'h0001);
    @(posedge clk_in);
    poll <= 1'b1;
    wr_reg(starter_pkg::REG_STATUS, 16'h0001);
    repeat (8) @(negedge clk_in);
    chk({15'h0, run}, 16'h0001);
    wr_reg(starter_pkg::REG_CMD, 16'h0005);
    @(negedge clk_in);
    chk({14'h0, reflash, remote}, 16'h0001);
    @(posedge clk_in);
    stop <= 1'b1;
    repeat (8) @(negedge clk_in);
    chk({15'h0, run}, 16'h0000);
    @(posedge clk_in);
    stop <= 1'b0;
    start <= 1'b0;
    wr_reg(starter_pkg::REG_CMD, 16'h0005);
    @(negedge clk_in);
    chk({14'h0, reflash, remote}, 16'h0002);
    wr_reg(starter_pkg::REG_SPAN, 16'h0032);
    rd_reg(starter_pkg::REG_SPAN, 16'h0050);
    rd_reg(starter_pkg::REG_STATUS, 16'h0082);
    // Power cycle is the only way out of reflash
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk({14'h0, reflash, remote}, 16'h0001);
    wr_reg(starter_pkg::REG_BAUD, 16'h0005);
    wr_reg(starter_pkg::REG_FRAME, 16'h0003);
    rd_reg(starter_pkg::REG_BAUD, 16'h0004);
    rd_reg(starter_pkg::REG_FRAME, 16'h0003);
    while (!ser.bit_en) begin
      @(negedge clk_in);
    end
    n = 1;
    @(negedge clk_in);
    while (!ser.bit_en) begin
      @(negedge clk_in);
      n++;
    end
    chk(16'(n), starter_pkg::DIV_19200);
    conclude();
  end
  initial begin
    repeat (6000) @(posedge clk_in);
    fail_count++;
    conclude();
  end
endmodule // tb_starter_supervision
